// ### cks_clock_select.sv
/*
 * cks_clock_select: register file and control decode for the converter
 * sampling clock source, delay loop, duty fix and data clock routing.
 * Assumes an Avalon-MM master on the same clock with word addressing;
 * the analog clock paths follow the control outputs of this block.
 */
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cks_clock_select #(
	parameter int RST_CYC = cks_pkg::DLL_RST_CYC,
	parameter int GAP_CYC = cks_pkg::SW_GAP_CYC
) (
	input wire logic clock, // control clock, 250 MHz
	input wire logic reset_n, // async reset, active low
	input wire logic [7:0] address, // word index
	input wire logic read, // read strobe
	input wire logic write, // write strobe
	input wire logic [31:0] writedata, // write data
	input wire logic [3:0] byteenable, // byte lanes
	output logic [31:0] readdata, // read data
	output logic waitrequest, // slave stall
	output logic coreSrcPll, // core clock mux: 1 phase loop
	output logic coreClkGate, // core clock gate on
	output logic pllClkGate, // phase-loop clock to converter
	output logic delayLoopOn, // delay loop powered
	output logic delayLoopRst, // delay loop in reset
	output logic dutyFixFallEdge, // duty fix on falling edge
	output logic [3:0] outClkSrc, // data clock source, one-hot
	output logic [2:0] outClkPhase, // data clock phase step
	output logic outClkDelayOn // data clock phase delay active
);
	// ============================================================
	// state
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [7:0] dllCtl;
		logic [7:0] srcSel;
		logic [7:0] outClk;
		logic [7:0] pllGate;
		logic [7:0] rstCnt;
		logic rstBusy;
	} cks_st_s;
	cks_st_s st_r;
	cks_st_s st_nxt;
	cks_sw_if swBus ();
	logic req;
	logic wrFire;
	logic lane0;
	logic dllEn;
	logic dllOut;
	logic phEn;
	logic srcPll;
	logic restartHit;
	// ============================================================
	// clock switch
	cks_switch #(
		.GAP_CYC(GAP_CYC)
	) uSwitch (
		.clock(clock),
		.reset_n(reset_n),
		.sw(swBus.sw)
	);
	// ============================================================
	// field views
	assign req = read | write;
	// a write lands at the edge where waitrequest is low
	assign wrFire = write & st_r.ack;
	assign lane0 = byteenable[0];
	assign dllEn = st_r.dllCtl[cks_pkg::DLL_EN_BIT];
	assign dllOut = st_r.dllCtl[cks_pkg::DLL_OUT_BIT];
	assign phEn = st_r.outClk[cks_pkg::PHDLY_EN_BIT];
	assign srcPll = st_r.srcSel[cks_pkg::SRC_BIT];
	assign swBus.wantPll = srcPll;
	// a restart landing as a countdown ends must start a fresh one
	assign restartHit = wrFire & lane0 & (address == cks_pkg::IDX_RESTART)
		& writedata[cks_pkg::RESTART_BIT] & dllEn;
	// ============================================================
	// read mux
	function automatic logic [31:0] rdMux(
		input logic [7:0] idx,
		input cks_st_s s,
		input logic actPll,
		input logic busy
	);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (idx)
			cks_pkg::IDX_DLLCTL: begin
				v[7:0] = s.dllCtl;
			end
			cks_pkg::IDX_SRCSEL: begin
				v[7:0] = s.srcSel;
			end
			cks_pkg::IDX_OUTCLK: begin
				v[7:0] = s.outClk;
			end
			cks_pkg::IDX_PLLGATE: begin
				v[7:0] = s.pllGate;
			end
			cks_pkg::IDX_STATUS: begin
				v[0] = actPll;
				v[1] = busy;
				v[2] = s.rstBusy;
			end
			default: begin
				v = 32'h0000_0000;
			end
		endcase
		return v;
	endfunction : rdMux
	// ============================================================
	// next state
	always_comb begin
		st_nxt = st_r;
		// one stall cycle per access, answer on the second
		st_nxt.ack = req & ~st_r.ack;
		if (req && !st_r.ack) begin
			st_nxt.rdata = rdMux(address, st_r, swBus.activePll,
				swBus.busy);
		end
		if (wrFire && lane0) begin
			case (address)
				cks_pkg::IDX_DLLCTL: begin
					// software write clears or sets the loop reset bit
					st_nxt.dllCtl = writedata[7:0];
				end
				cks_pkg::IDX_SRCSEL: begin
					st_nxt.srcSel = writedata[7:0];
				end
				cks_pkg::IDX_OUTCLK: begin
					st_nxt.outClk = writedata[7:0];
				end
				cks_pkg::IDX_PLLGATE: begin
					st_nxt.pllGate = writedata[7:0];
				end
				cks_pkg::IDX_RESTART: begin
					if (writedata[cks_pkg::RESTART_BIT] && dllEn) begin
						st_nxt.rstBusy = 1'b1;
						st_nxt.rstCnt = 8'(RST_CYC);
					end
				end
				default: begin
					st_nxt.rstBusy = st_r.rstBusy;
				end
			endcase
		end
		// the restart set wins over the countdown's own end
		if (st_r.rstBusy && !restartHit) begin
			if (st_r.rstCnt <= 8'h01) begin
				st_nxt.rstBusy = 1'b0;
				// hardware clear wins over a write in the same cycle
				st_nxt.dllCtl[cks_pkg::DLL_RST_BIT] = 1'b0;
			end else begin
				st_nxt.rstCnt = st_r.rstCnt - 8'h01;
				st_nxt.dllCtl[cks_pkg::DLL_RST_BIT] = 1'b1;
			end
		end
	end
	// ============================================================
	// registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_r.ack <= 1'b0;
			st_r.rdata <= 32'h0000_0000;
			st_r.dllCtl <= cks_pkg::DLLCTL_RST;
			st_r.srcSel <= cks_pkg::SRCSEL_RST;
			st_r.outClk <= cks_pkg::OUTCLK_RST;
			st_r.pllGate <= cks_pkg::PLLGATE_RST;
			st_r.rstCnt <= 8'h00;
			st_r.rstBusy <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end
	// ============================================================
	// bus answers
	assign waitrequest = req & ~st_r.ack;
	assign readdata = st_r.rdata;
	// ============================================================
	// core clock path
	assign coreSrcPll = swBus.activePll;
	// the phase-loop clock is only let through while its gate bit is set
	assign pllClkGate = swBus.activePll & swBus.gateOn
		& st_r.pllGate[cks_pkg::PLL_GATE_BIT];
	assign coreClkGate = swBus.gateOn
		& (~swBus.activePll | st_r.pllGate[cks_pkg::PLL_GATE_BIT]);
	// loop enables are ignored in phase-loop mode, except that dllEn still gates a restart
	// the loop keeps running until the core has really left it
	assign delayLoopOn = dllEn & ~swBus.activePll;
	assign delayLoopRst = st_r.dllCtl[cks_pkg::DLL_RST_BIT]
		| st_r.rstBusy;
	// correction only trims the falling edge; rising edge stays put
	assign dutyFixFallEdge = st_r.dllCtl[cks_pkg::DUTY_EN_BIT] & dllEn
		& ~srcPll & ~swBus.activePll;
	// ============================================================
	// data clock routing
	always_comb begin
		if (phEn) begin
			outClkSrc = cks_pkg::OCK_DECIM;
			outClkPhase = st_r.outClk[cks_pkg::DEC_PH_LSB +:
				cks_pkg::PH_W];
			outClkDelayOn = 1'b1;
		end else if (swBus.activePll) begin
			outClkSrc = cks_pkg::OCK_PLL;
			outClkPhase = 3'h0;
			outClkDelayOn = 1'b1;
		end else if (dllEn && dllOut) begin
			outClkSrc = cks_pkg::OCK_DLL;
			outClkPhase = st_r.dllCtl[cks_pkg::DLL_PH_LSB +:
				cks_pkg::PH_W];
			outClkDelayOn = 1'b1;
		end else begin
			// straight from the input buffer, no delay control
			outClkSrc = cks_pkg::OCK_BUFFER;
			outClkPhase = 3'h0;
			outClkDelayOn = 1'b0;
		end
	end
endmodule : cks_clock_select
`default_nettype wire

// ### cks_pkg.sv
/*
 * cks_pkg: shared constants for the converter clock source select block.
 * Register indices, field positions, reset values, state codes and timing.
 * Assumes a 250 MHz control clock; printed offsets are word indices.
 */
// ============================================================
package cks_pkg;
	// ============================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_RESTART = 8'h00;
	localparam logic [7:0] IDX_DLLCTL = 8'h52;
	localparam logic [7:0] IDX_SRCSEL = 8'h53;
	localparam logic [7:0] IDX_OUTCLK = 8'h64;
	localparam logic [7:0] IDX_PLLGATE = 8'h6D;
	localparam logic [7:0] IDX_STATUS = 8'h70;
	// ============================================================
	// field positions
	localparam int RESTART_BIT = 0;
	localparam int DLL_EN_BIT = 0;
	localparam int DUTY_EN_BIT = 1;
	localparam int DLL_OUT_BIT = 2;
	localparam int DLL_PH_LSB = 3;
	localparam int DLL_RST_BIT = 6;
	localparam int SRC_BIT = 0;
	localparam int PHDLY_EN_BIT = 0;
	localparam int DEC_PH_LSB = 1;
	localparam int PLL_GATE_BIT = 0;
	localparam int PH_W = 3;
	// ============================================================
	// reset values
	localparam logic [7:0] DLLCTL_RST = 8'h40;
	localparam logic [7:0] SRCSEL_RST = 8'h00;
	localparam logic [7:0] OUTCLK_RST = 8'h00;
	localparam logic [7:0] PLLGATE_RST = 8'h00;
	// ============================================================
	// data clock sources
	typedef enum logic [3:0] {
		OCK_BUFFER = 4'h1,
		OCK_DLL = 4'h2,
		OCK_PLL = 4'h4,
		OCK_DECIM = 4'h8
	} cks_ock_e;
	// switch sequencer states, one-hot
	typedef enum logic [3:0] {
		SW_RUN = 4'h1,
		SW_GATEOFF = 4'h2,
		SW_SWAP = 4'h4,
		SW_GATEON = 4'h8
	} cks_sw_e;
	// ============================================================
	// timing
	localparam int CLK_MHZ = 250;
	localparam int DLL_RST_NS = 100;
	localparam int DLL_RST_CYC = (DLL_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int SW_GAP_NS = 8;
	localparam int SW_GAP_CYC = (SW_GAP_NS * CLK_MHZ + 999) / 1000;
endpackage : cks_pkg

// ### cks_sw_if.sv
/*
 * cks_sw_if: request and status between register logic and clock switch.
 * Assumes both ends sit on the same control clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface cks_sw_if;
	logic wantPll;
	logic activePll;
	logic gateOn;
	logic busy;
	modport ctl (output wantPll, input activePll, gateOn, busy);
	modport sw (input wantPll, output activePll, gateOn, busy);
endinterface : cks_sw_if
`default_nettype wire

// ### cks_switch.sv
/*
 * cks_switch: break-before-make sequencer for the core clock source mux.
 * Assumes the analog mux and gates follow activePll and gateOn directly.
 */
`timescale 1ns/10ps
`default_nettype none
module cks_switch #(
	parameter int GAP_CYC = cks_pkg::SW_GAP_CYC
) (
	input wire logic clock, // control clock
	input wire logic reset_n, // async reset, active low
	cks_sw_if.sw sw // switch request and status
);
	typedef struct packed {
		cks_pkg::cks_sw_e st;
		logic activePll;
		logic [7:0] cnt;
	} cks_swst_s;
	cks_swst_s s_r;
	cks_swst_s s_nxt;
	// ============================================================
	// sequencer: gate off, wait, swap, wait, gate on
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			cks_pkg::SW_RUN: begin
				if (sw.wantPll != s_r.activePll) begin
					s_nxt.st = cks_pkg::SW_GATEOFF;
					s_nxt.cnt = 8'(GAP_CYC);
				end
			end
			cks_pkg::SW_GATEOFF: begin
				if (s_r.cnt <= 8'h01) begin
					s_nxt.st = cks_pkg::SW_SWAP;
					s_nxt.activePll = sw.wantPll;
					s_nxt.cnt = 8'(GAP_CYC);
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
			cks_pkg::SW_SWAP: begin
				if (s_r.cnt <= 8'h01) begin
					s_nxt.st = cks_pkg::SW_GATEON;
				end else begin
					s_nxt.cnt = s_r.cnt - 8'h01;
				end
			end
			cks_pkg::SW_GATEON: begin
				s_nxt.st = cks_pkg::SW_RUN;
			end
			default: begin
				s_nxt.st = cks_pkg::SW_RUN;
			end
		endcase
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '{st: cks_pkg::SW_RUN, activePll: 1'b0, cnt: 8'h00};
		end else begin
			s_r <= s_nxt;
		end
	end
	// gate held low through both waits so no runt pulse escapes
	assign sw.gateOn = (s_r.st == cks_pkg::SW_RUN);
	assign sw.busy = (s_r.st != cks_pkg::SW_RUN);
	assign sw.activePll = s_r.activePll;
endmodule : cks_switch
`default_nettype wire

// ### cks_clock_select_asserts.sv
/* cks_cs_asserts: port-level checks for the clock select block.
   Bound onto cks_clock_select; sees only its top-level ports. */
`timescale 1ns/10ps
`default_nettype none
module cks_cs_asserts #(
	parameter int RST_CYC = cks_pkg::DLL_RST_CYC,
	parameter int GAP_CYC = cks_pkg::SW_GAP_CYC
) (
	input wire logic clock, // control clock
	input wire logic reset_n, // async reset, active low
	input wire logic read, // read strobe
	input wire logic write, // write strobe
	input wire logic waitrequest, // slave stall
	input wire logic coreSrcPll, // core mux select
	input wire logic coreClkGate, // core clock gate
	input wire logic pllClkGate, // phase-loop clock gate
	input wire logic delayLoopOn, // delay loop powered
	input wire logic dutyFixFallEdge, // duty fix active
	input wire logic [3:0] outClkSrc, // data clock source
	input wire logic [2:0] outClkPhase, // data clock phase
	input wire logic outClkDelayOn // phase delay active
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// ==========
	// bus and clock routing
	a_one_stall: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus stall longer than one cycle");
	a_duty_loop: assert property (dutyFixFallEdge |-> delayLoopOn && !coreSrcPll)
		else $error("duty fix without delay loop");
	a_pll_gate: assert property (pllClkGate |-> coreSrcPll && coreClkGate && !delayLoopOn)
		else $error("phase-loop clock gated wrongly");
	a_core_gate: assert property (coreSrcPll && coreClkGate |-> pllClkGate)
		else $error("core runs on ungated phase loop");
	a_buf_plain: assert property (outClkSrc == 4'h1 |-> !outClkDelayOn && outClkPhase == 3'h0)
		else $error("buffer data clock has delay");
	a_loop_clk: assert property (outClkSrc == 4'h2 |-> delayLoopOn && outClkDelayOn)
		else $error("loop data clock without loop");
	a_src_onehot: assert property ($onehot(outClkSrc))
		else $error("data clock source not one-hot");
	a_pll_out: assert property (outClkSrc == 4'h4 |-> coreSrcPll && outClkDelayOn)
		else $error("phase-loop data clock mismatch");
	// the mux may only move while the gate has been low a full cycle
	a_clean_swap: assert property ($changed(coreSrcPll) |-> !$past(coreClkGate) && !coreClkGate ##1 !coreClkGate)
		else $error("core mux swapped with gate open");
	c_to_pll: cover property ($rose(coreSrcPll));
	c_duty: cover property (dutyFixFallEdge);
	c_decim: cover property (outClkSrc == 4'h8);
endmodule : cks_cs_asserts
bind cks_clock_select cks_cs_asserts #(.RST_CYC(RST_CYC), .GAP_CYC(GAP_CYC)) cks_cs_asserts_i (.*);
`default_nettype wire

// ### cks_host_model.sv
/* cks_host_model: configuring host, an Avalon-MM master with tasks.
   Assumes the slave answers with waitrequest on the same clock. */
`timescale 1ns/10ps
`default_nettype none
module cks_host_model (
	input wire logic clock, // control clock
	input wire logic waitrequest, // slave stall
	input wire logic [31:0] readdata, // read data
	output logic [7:0] address, // word index
	output logic read, // read strobe
	output logic write, // write strobe
	output logic [31:0] writedata, // write data
	output logic [3:0] byteenable // byte lanes
);
	// duty fix is only set in deliberate test cases
	// phase-loop mode is only chosen with a 250 MHz reference
	// loop reset is issued through restart before the source moves
	initial begin
		address <= 8'h00;
		read <= 1'b0;
		write <= 1'b0;
		writedata <= 32'h0;
		byteenable <= 4'h0;
	end
	// waits as long as the slave stalls; only the bench watchdog ends a hang
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] be);
		@(posedge clock);
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= be;
		write <= 1'b1;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		address <= a;
		read <= 1'b1;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
	endtask : rd
endmodule : cks_host_model
`default_nettype wire

// ### cks_clock_select_tb.sv
/* cks_clock_select_tb: self-checking bench for the clock select block.
   Assumes the host model speaks the bus; short loop reset and gap. */
`timescale 1ns/10ps
`default_nettype none
module cks_clock_select_tb;
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] oc;
		logic on;
		logic duty;
		logic [3:0] src;
		logic dly;
		logic [2:0] ph;
	} cks_row_s;
	localparam int RST = 3;
	localparam cks_row_s ROWS [8] = '{
		'{8'h01, 8'h00, 1'b1, 1'b0, 4'h1, 1'b0, 3'h0},
		'{8'h03, 8'h00, 1'b1, 1'b1, 4'h1, 1'b0, 3'h0},
		'{8'h02, 8'h00, 1'b0, 1'b0, 4'h1, 1'b0, 3'h0},
		'{8'h1D, 8'h00, 1'b1, 1'b0, 4'h2, 1'b1, 3'h3},
		'{8'h04, 8'h00, 1'b0, 1'b0, 4'h1, 1'b0, 3'h0},
		'{8'h00, 8'h0B, 1'b0, 1'b0, 4'h8, 1'b1, 3'h5},
		'{8'h3F, 8'h05, 1'b1, 1'b1, 4'h8, 1'b1, 3'h2},
		'{8'h00, 8'h00, 1'b0, 1'b0, 4'h1, 1'b0, 3'h0}};
	logic clock, reset_n, read, write, waitrequest, coreSrcPll, coreClkGate;
	logic pllClkGate, delayLoopOn, delayLoopRst, dutyFixFallEdge, outClkDelayOn;
	logic [7:0] address;
	logic [31:0] writedata, readdata, rdat;
	logic [3:0] byteenable, outClkSrc;
	logic [2:0] outClkPhase;
	int badCount = 0;
	int checked = 0;
	cks_host_model cks_host_model_i (.clock(clock), .waitrequest(waitrequest),
		.readdata(readdata), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable));
	cks_clock_select #(.RST_CYC(RST), .GAP_CYC(1)) cks_clock_select_i (.*);
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic chkb(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			badCount++;
			$display("[FAIL] %0t flag mismatch", $time);
		end
	endtask : chkb
	task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			badCount++;
			$display("[FAIL] %0t value %0h expected %0h", $time, got, exp);
		end
	endtask : chkw
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		cks_host_model_i.rd(a, rdat);
		chkw(rdat, exp);
	endtask : rdchk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cks_host_model_i.wr(a, d, 4'hF);
	endtask : wr
	task automatic waitGate(input logic s);
		int n;
		n = 0;
		while (!(coreSrcPll === s && coreClkGate === 1'b1) && n < 40) begin
			@(negedge clock);
			n++;
		end
		chkb(coreSrcPll, s);
		chkb(coreClkGate, 1'b1);
	endtask : waitGate
	task wrap_up;
		$display("checks %0d mismatches %0d", checked, badCount);
		if (badCount == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (4000) @(posedge clock);
		badCount++;
		wrap_up();
	end
	initial begin
		reset_n = 1'b0;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		@(negedge clock);
		chkb(delayLoopRst, 1'b1);
		chkb(coreSrcPll, 1'b0);
		chkw({28'h0, outClkSrc}, 32'h1);
		rdchk(cks_pkg::IDX_DLLCTL, 32'h40);
		rdchk(8'h11, 32'h0);
		cks_host_model_i.wr(cks_pkg::IDX_SRCSEL, 8'h01, 4'h0);
		rdchk(cks_pkg::IDX_SRCSEL, 32'h0);
		foreach (ROWS[i]) begin
			wr(cks_pkg::IDX_OUTCLK, ROWS[i].oc);
			wr(cks_pkg::IDX_DLLCTL, ROWS[i].ctl);
			@(negedge clock);
			chkb(delayLoopOn, ROWS[i].on);
			chkb(dutyFixFallEdge, ROWS[i].duty);
			chkw({28'h0, outClkSrc}, {28'h0, ROWS[i].src});
			chkb(outClkDelayOn, ROWS[i].dly);
			chkw({29'h0, outClkPhase}, {29'h0, ROWS[i].ph});
			chkb(delayLoopRst, 1'b0);
		end
		wr(cks_pkg::IDX_DLLCTL, 8'h03);
		wr(cks_pkg::IDX_RESTART, 8'h01);
		@(negedge clock);
		chkb(delayLoopRst, 1'b1);
		rdchk(cks_pkg::IDX_STATUS, 32'h4);
		repeat (RST + 4) @(negedge clock);
		chkb(delayLoopRst, 1'b0);
		rdchk(cks_pkg::IDX_DLLCTL, 32'h03);
		wr(cks_pkg::IDX_DLLCTL, 8'h02);
		wr(cks_pkg::IDX_RESTART, 8'h01);
		@(negedge clock);
		chkb(delayLoopRst, 1'b0);
		wr(cks_pkg::IDX_DLLCTL, 8'h07);
		wr(cks_pkg::IDX_PLLGATE, 8'h01);
		wr(cks_pkg::IDX_SRCSEL, 8'h01);
		waitGate(1'b1);
		chkb(pllClkGate, 1'b1);
		chkb(delayLoopOn, 1'b0);
		chkb(dutyFixFallEdge, 1'b0);
		chkw({28'h0, outClkSrc}, 32'h4);
		chkb(outClkDelayOn, 1'b1);
		rdchk(cks_pkg::IDX_STATUS, 32'h1);
		wr(cks_pkg::IDX_PLLGATE, 8'h00);
		@(negedge clock);
		chkb(pllClkGate, 1'b0);
		chkb(coreClkGate, 1'b0);
		wr(cks_pkg::IDX_SRCSEL, 8'h00);
		waitGate(1'b0);
		chkb(dutyFixFallEdge, 1'b1);
		chkw({28'h0, outClkSrc}, 32'h2);
		// reset in mid-run must bring every control back to its default
		@(posedge clock);
		reset_n <= 1'b0;
		@(negedge clock);
		chkb(delayLoopRst, 1'b1);
		chkb(dutyFixFallEdge, 1'b0);
		chkw({28'h0, outClkSrc}, 32'h1);
		@(posedge clock);
		reset_n <= 1'b1;
		@(negedge clock);
		chkb(coreSrcPll, 1'b0);
		chkb(coreClkGate, 1'b1);
		rdchk(cks_pkg::IDX_DLLCTL, 32'h40);
		wrap_up();
	end
endmodule : cks_clock_select_tb
`default_nettype wire
